/* src/dmsc_local_time.sv */
// Purpose: Daylight saving control and minute sync for the real-time clock
// Assumes: Classic Wishbone slave; dig_in_i are asynchronous pins
// Notes:   Registered ack, one wait cycle; unmapped reads return zero
`timescale 1ns/100ps
`default_nettype none
module dmsc_local_time #(
  parameter int DI_COUNT = 14
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Time base and pins
  input  wire logic        tick_i,
  input  wire logic [DI_COUNT-1:0] dig_in_i,
  // Clock state
  output logic      [5:0]  sec_o,
  output logic      [5:0]  min_o,
  output logic      [4:0]  hour_o,
  output logic      [4:0]  day_o,
  output logic      [3:0]  mon_o,
  output logic      [6:0]  year_o,
  output logic      [2:0]  wday_o,
  output logic             dst_active_o,
  output logic      [1:0]  date_order_o,
  output logic      [3:0]  country_o
);

  // ****************************************************************
  // Checks and core
  // ****************************************************************
  if (DI_COUNT < 14) begin : g_bad_di
    $error("DI_COUNT must cover input fourteen");
  end

  dmsc_rtc_if rt ();
  dmsc_rtc_core u_core (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .rt    (rt.core)
  );

  // Clock state straight from the core registers
  assign sec_o  = rt.sec;
  assign min_o  = rt.min;
  assign hour_o = rt.hour;
  assign day_o  = rt.day;
  assign mon_o  = rt.mon;
  assign year_o = rt.year;
  assign wday_o = rt.wday;
  assign rt.tick = tick_i;

  // ****************************************************************
  // Settings
  // ****************************************************************
  logic                 dst_en;
  logic [3:0]           sync_sel;
  dmsc_pkg::dmsc_spec_t start_spec;
  dmsc_pkg::dmsc_spec_t end_spec;
  logic [31:0]          ctrl_word, start_word, end_word, time_word;
  logic [31:0]          date_word, rd_word, mask, merged;
  logic                 req, wr, ctrl_ok, start_ok, end_ok;
  dmsc_pkg::dmsc_spec_t new_spec;

  // Bus decode and read selection
  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr         = req & wb_we_i;
  assign ctrl_word  = {20'h0, country_o, sync_sel, 1'b0, date_order_o,
                       dst_en};
  assign start_word = {17'h0, start_spec.hour, 1'b0, start_spec.wday,
                       1'b0, start_spec.week, start_spec.mon};
  assign end_word   = {17'h0, end_spec.hour, 1'b0, end_spec.wday,
                       1'b0, end_spec.week, end_spec.mon};
  assign time_word  = {11'h0, rt.hour, 2'h0, rt.min, 2'h0, rt.sec};
  assign date_word  = {5'h0, rt.wday, 1'b0, rt.year, 4'h0, rt.mon,
                       3'h0, rt.day};
  assign rd_word    = (wb_adr_i == dmsc_pkg::ADR_CTRL)  ? ctrl_word  :
                      (wb_adr_i == dmsc_pkg::ADR_START) ? start_word :
                      (wb_adr_i == dmsc_pkg::ADR_END)   ? end_word   :
                      (wb_adr_i == dmsc_pkg::ADR_TIME)  ? time_word  :
                      (wb_adr_i == dmsc_pkg::ADR_DATE)  ? date_word  :
                      (wb_adr_i == dmsc_pkg::ADR_STAT)  ?
                        {31'h0, dst_active_o} : 32'h0;

  // Byte lanes merge new data over the current contents
  assign mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign merged = (rd_word & ~mask) | (wb_dat_i & mask);

  assign new_spec.mon  = merged[dmsc_pkg::SPEC_MON +: 4];
  assign new_spec.week = merged[dmsc_pkg::SPEC_WEEK +: 3];
  assign new_spec.wday = merged[dmsc_pkg::SPEC_WDAY +: 3];
  assign new_spec.hour = merged[dmsc_pkg::SPEC_HOUR +: 3];
  assign start_ok = (new_spec.mon >= 4'h1) &&
                    (new_spec.mon <= dmsc_pkg::MON_MAX) &&
                    (new_spec.week >= 3'h1) &&
                    (new_spec.week <= dmsc_pkg::WEEK_LAST) &&
                    (new_spec.wday <= dmsc_pkg::WDAY_MAX) &&
                    (new_spec.hour >= dmsc_pkg::SPEC_HOUR_MIN) &&
                    (new_spec.hour <= dmsc_pkg::SPEC_HOUR_MAX);
  assign end_ok   = start_ok;
  assign ctrl_ok  = (merged[dmsc_pkg::CTRL_SYNC +: 4] <=
                     dmsc_pkg::SYNC_DIGITAL_INPUT_FOURTEEN) &&
                    (merged[dmsc_pkg::CTRL_ORDER +: 2] <=
                     dmsc_pkg::DMSC_YMD);

  // Settings registers; out-of-range writes are ignored
  // reset defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dst_en       <= 1'b0;
      date_order_o <= dmsc_pkg::DMSC_DMY;
      sync_sel     <= dmsc_pkg::SYNC_NONE;
      country_o    <= dmsc_pkg::COUNTRY_DEF;
      start_spec   <= dmsc_pkg::START_RESET;
      end_spec     <= dmsc_pkg::END_RESET;
    end else if (wr) begin
      if (wb_adr_i == dmsc_pkg::ADR_CTRL && ctrl_ok) begin
        dst_en       <= merged[dmsc_pkg::CTRL_DST_EN];
        date_order_o <= merged[dmsc_pkg::CTRL_ORDER +: 2];
        sync_sel     <= merged[dmsc_pkg::CTRL_SYNC +: 4];
        country_o    <= merged[dmsc_pkg::CTRL_COUNTRY +: 4];
      end
      if (wb_adr_i == dmsc_pkg::ADR_START && start_ok) begin
        start_spec <= new_spec;
      end
      if (wb_adr_i == dmsc_pkg::ADR_END && end_ok) begin
        end_spec <= new_spec;
      end
    end
  end

  // Bus answer and time or date load strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0;
      rt.load_time <= 1'b0;
      rt.load_date <= 1'b0;
      rt.wdata     <= 32'h0;
    end else begin
      wb_ack_o     <= req;
      wb_dat_o     <= req ? rd_word : 32'h0;
      rt.load_time <= wr & (wb_adr_i == dmsc_pkg::ADR_TIME);
      rt.load_date <= wr & (wb_adr_i == dmsc_pkg::ADR_DATE);
      rt.wdata     <= merged;
    end
  end

  // ****************************************************************
  // Minute sync input
  // ****************************************************************
  logic [DI_COUNT-1:0] di_meta, di_sync;
  logic                sync_level, sync_prev, sync_edge;

  for (genvar i = 0; i < DI_COUNT; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        di_meta[i] <= 1'b0;
        di_sync[i] <= 1'b0;
      end else begin
        di_meta[i] <= dig_in_i[i];
        di_sync[i] <= di_meta[i];
      end
    end
  end

  // source selection, none gives a quiet level
  assign sync_level = (sync_sel >= 4'h1 &&
                       sync_sel <= dmsc_pkg::SYNC_LAST_LOW) ?
                        di_sync[sync_sel - 4'h1] :
                      (sync_sel == dmsc_pkg::SYNC_DIGITAL_INPUT_FOURTEEN) ? di_sync[13] : 1'b0;
  assign sync_edge  = sync_level & ~sync_prev;

  // rising edge asks the core to round
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_prev    <= 1'b0;
      rt.round_min <= 1'b0;
    end else begin
      sync_prev    <= sync_level;
      rt.round_min <= sync_edge;
    end
  end

  // ****************************************************************
  // Daylight saving transitions
  // ****************************************************************
  logic [4:0] dim;
  logic       at_hour_top, start_hit, end_hit;

  // Week slot test, the last-week code checks the month end
  function automatic logic on_point(input dmsc_pkg::dmsc_spec_t sp,
                                    input logic [4:0] day,
                                    input logic [4:0] lim);
    logic [4:0] first;
    first = (5'(sp.week) - 5'h01) * 5'h07 + 5'h01;
    if (sp.week == dmsc_pkg::WEEK_LAST) begin
      return 6'(day) + 6'(dmsc_pkg::WEEK_DAYS) > 6'(lim);
    end
    return (day >= first) && (day < first + dmsc_pkg::WEEK_DAYS);
  endfunction

  assign dim         = dmsc_pkg::days_in_month(rt.mon, rt.year);
  assign at_hour_top = (rt.sec == 6'h00) && (rt.min == 6'h00) &&
                       !rt.load_time && !rt.load_date;
  // start and end matches gated by the flag
  assign start_hit = dst_en && !dst_active_o && at_hour_top &&
                     rt.mon == start_spec.mon && rt.wday == start_spec.wday &&
                     rt.hour == {2'h0, start_spec.hour} &&
                     on_point(start_spec, rt.day, dim);
  assign end_hit   = dst_en && dst_active_o && at_hour_top &&
                     rt.mon == end_spec.mon && rt.wday == end_spec.wday &&
                     rt.hour == {2'h0, end_spec.hour} &&
                     on_point(end_spec, rt.day, dim);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dst_active_o <= 1'b0;
      rt.hour_fwd  <= 1'b0;
      rt.hour_back <= 1'b0;
    end else begin
      dst_active_o <= dst_en && (start_hit || (dst_active_o && !end_hit));
      rt.hour_fwd  <= start_hit;
      rt.hour_back <= end_hit;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fwd_cmd;
    rt.hour_fwd && !rt.load_time;
  endsequence
  sequence s_back_cmd;
    rt.hour_back && !rt.load_time;
  endsequence

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_hour_forward: assert property (s_fwd_cmd |=>
    rt.hour == $past(rt.hour) + 5'h01) else $error("forward shift wrong");
  a_hour_back: assert property (s_back_cmd |=>
    rt.hour == $past(rt.hour) - 5'h01) else $error("back shift wrong");
  a_disabled_no_shift: assert property (!dst_en |=>
    !dst_active_o && !rt.hour_fwd && !rt.hour_back)
    else $error("shift while disabled");
  a_start_hour_range: assert property (start_spec.hour >= 3'h1 &&
    start_spec.hour <= 3'h6) else $error("start hour out of range");
  a_end_month_range: assert property (end_spec.mon >= 4'h1 &&
    end_spec.mon <= 4'hc && end_spec.hour >= 3'h1) else $error("bad end");
  a_last_week_pick: assert property (rt.hour_back &&
    end_spec.week == dmsc_pkg::WEEK_LAST |-> 6'(rt.day) + 6'h07 > 6'(dim))
    else $error("last week resolved wrong");
  a_sync_rounds_sec: assert property ($rose(sync_level) &&
    !$rose(rt.load_time) |-> ##2 rt.sec == 6'h00)
    else $error("sync edge did not round");
  a_sync_none_quiet: assert property (sync_sel == 4'h0 |=>
    !rt.round_min) else $error("round seen with no source");
  a_order_legal: assert property (date_order_o != 2'h3)
    else $error("illegal date order");
  a_flag_once: assert property ($rose(dst_active_o) |->
    rt.hour_fwd ##1 !rt.hour_fwd [*3]) else $error("forward shift repeated");

endmodule
`default_nettype wire

/* src/dmsc_pkg.sv */
// Purpose: Constants, types and calendar helpers for the local-time block
// Assumes: Byte-addressed classic Wishbone, 32-bit data, one word per register
// Notes:   Years run 00..99 within one century, every fourth one leap
//
// How it works
// - With daylight saving on, the clock jumps one hour ahead at start.
// - With daylight saving off, no hour is ever shifted; off after reset.
// - Start point is month, week, weekday, hour 1-6; March/2nd/Sun/2h.
// - End point is month, week, weekday, hour 1-6; Nov/1st/Sun/2h.
// - Week is 1 to 4 or a last-week code meaning the final such weekday.
// - Sync source is none, input 1-7 or input 14; none after reset.
// - Each rising edge on the chosen input rounds to the nearest minute.
// - Date order is DMY, MDY or YMD, with DMY after reset.
package dmsc_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_START = 8'h04;
  localparam logic [7:0] ADR_END   = 8'h08;
  localparam logic [7:0] ADR_TIME  = 8'h0c;
  localparam logic [7:0] ADR_DATE  = 8'h10;
  localparam logic [7:0] ADR_STAT  = 8'h14;

  localparam int CTRL_DST_EN   = 0;
  localparam int CTRL_ORDER    = 1;
  localparam int CTRL_SYNC     = 4;
  localparam int CTRL_COUNTRY  = 8;
  localparam int SPEC_MON      = 0;
  localparam int SPEC_WEEK     = 4;
  localparam int SPEC_WDAY     = 8;
  localparam int SPEC_HOUR     = 12;
  localparam int TIME_SEC      = 0;
  localparam int TIME_MIN      = 8;
  localparam int TIME_HOUR     = 16;
  localparam int DATE_DAY      = 0;
  localparam int DATE_MON      = 8;
  localparam int DATE_YEAR     = 16;
  localparam int DATE_WDAY     = 24;

  // ****************************************************************
  // Codes, limits and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    DMSC_DMY = 2'b00,
    DMSC_MDY = 2'b01,
    DMSC_YMD = 2'b10
  } dmsc_order_t;

  typedef struct packed {
    logic [3:0] mon;
    logic [2:0] week;
    logic [2:0] wday;
    logic [2:0] hour;
  } dmsc_spec_t;

  localparam logic [2:0] WEEK_LAST     = 3'h5;
  localparam logic [3:0] SYNC_NONE     = 4'h0;
  localparam logic [3:0] SYNC_LAST_LOW = 4'h7;
  localparam logic [3:0] SYNC_DIGITAL_INPUT_FOURTEEN     = 4'h8;
  localparam logic [3:0] COUNTRY_DEF   = 4'h0;
  localparam logic [2:0] SPEC_HOUR_MIN = 3'h1;
  localparam logic [2:0] SPEC_HOUR_MAX = 3'h6;
  localparam logic [4:0] WEEK_DAYS     = 5'h07;
  localparam logic [5:0] SEC_MAX       = 6'h3b;
  localparam logic [5:0] MIN_MAX       = 6'h3b;
  localparam logic [5:0] ROUND_UP_SEC  = 6'h1e;
  localparam logic [4:0] HOUR_MAX      = 5'h17;
  localparam logic [3:0] MON_MAX       = 4'hc;
  localparam logic [6:0] YEAR_MAX      = 7'h63;
  localparam logic [2:0] WDAY_MAX      = 3'h6;
  localparam logic [2:0] WDAY_RESET    = 3'h6;

  localparam dmsc_spec_t START_RESET = '{4'h3, 3'h2, 3'h0, 3'h2};
  localparam dmsc_spec_t END_RESET   = '{4'hb, 3'h1, 3'h0, 3'h2};

  // Length of a month, February by leap year
  function automatic logic [4:0] days_in_month(input logic [3:0] mon,
                                               input logic [6:0] year);
    case (mon)
      4'h2:                      return (year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb:    return 5'h1e;
      default:                   return 5'h1f;
    endcase
  endfunction

endpackage

/* src/dmsc_rtc_core.sv */
// Purpose: Seconds-to-years timekeeping with hour shift and minute rounding
// Assumes: tick is a one-second pulse on clk_i
// Notes:   Loads win over all other updates
`timescale 1ns/100ps
`default_nettype none
module dmsc_rtc_core (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Controller side
  dmsc_rtc_if.core  rt
);

  // ****************************************************************
  // Carry chain
  // ****************************************************************
  logic [4:0] dim;
  logic       sec_up, sec_wrap, round_up, min_inc, min_wrap;
  logic       hour_wrap, day_wrap, mon_wrap;
  logic [5:0] next_sec, next_min;
  logic [4:0] next_hour, next_day;
  logic [3:0] next_mon;
  logic [6:0] next_year;
  logic [2:0] next_wday;

  // Carries ripple from seconds, or from a rounded-up minute
  assign dim       = dmsc_pkg::days_in_month(rt.mon, rt.year);
  assign sec_up    = rt.tick & ~rt.round_min;
  assign sec_wrap  = sec_up & (rt.sec == dmsc_pkg::SEC_MAX);
  assign round_up  = rt.round_min & (rt.sec >= dmsc_pkg::ROUND_UP_SEC);
  assign min_inc   = sec_wrap | round_up;
  assign min_wrap  = min_inc & (rt.min == dmsc_pkg::MIN_MAX);
  assign hour_wrap = min_wrap & (rt.hour == dmsc_pkg::HOUR_MAX);
  assign day_wrap  = hour_wrap & (rt.day == dim);
  assign mon_wrap  = day_wrap & (rt.mon == dmsc_pkg::MON_MAX);

  // Next values; hour shifts only occur at hh:00:00, so no carry meets them
  assign next_sec  = (rt.round_min | sec_wrap) ? 6'h00 :
                     sec_up ? rt.sec + 6'h01 : rt.sec;
  assign next_min  = min_wrap ? 6'h00 : min_inc ? rt.min + 6'h01 : rt.min;
  assign next_hour = hour_wrap ? 5'h00 :
                     (min_wrap | rt.hour_fwd) ? rt.hour + 5'h01 :
                     rt.hour_back ? rt.hour - 5'h01 : rt.hour;
  assign next_day  = day_wrap ? 5'h01 : hour_wrap ? rt.day + 5'h01 : rt.day;
  assign next_wday = !hour_wrap ? rt.wday :
                     (rt.wday == dmsc_pkg::WDAY_MAX) ? 3'h0 :
                     rt.wday + 3'h1;
  assign next_mon  = mon_wrap ? 4'h1 : day_wrap ? rt.mon + 4'h1 : rt.mon;
  assign next_year = !mon_wrap ? rt.year :
                     (rt.year == dmsc_pkg::YEAR_MAX) ? 7'h00 :
                     rt.year + 7'h01;

  // Time of day registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt.sec  <= 6'h00;
      rt.min  <= 6'h00;
      rt.hour <= 5'h00;
    end else if (rt.load_time) begin
      rt.sec  <= rt.wdata[dmsc_pkg::TIME_SEC +: 6];
      rt.min  <= rt.wdata[dmsc_pkg::TIME_MIN +: 6];
      rt.hour <= rt.wdata[dmsc_pkg::TIME_HOUR +: 5];
    end else begin
      rt.sec  <= next_sec;
      rt.min  <= next_min;
      rt.hour <= next_hour;
    end
  end

  // Calendar registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt.day  <= 5'h01;
      rt.mon  <= 4'h1;
      rt.year <= 7'h00;
      rt.wday <= dmsc_pkg::WDAY_RESET;
    end else if (rt.load_date) begin
      rt.day  <= rt.wdata[dmsc_pkg::DATE_DAY +: 5];
      rt.mon  <= rt.wdata[dmsc_pkg::DATE_MON +: 4];
      rt.year <= rt.wdata[dmsc_pkg::DATE_YEAR +: 7];
      rt.wday <= rt.wdata[dmsc_pkg::DATE_WDAY +: 3];
    end else begin
      rt.day  <= next_day;
      rt.mon  <= next_mon;
      rt.year <= next_year;
      rt.wday <= next_wday;
    end
  end

endmodule
`default_nettype wire

/* src/dmsc_rtc_if.sv */
// Purpose: Link between the local-time controller and the timekeeping core
// Assumes: Both ends share one clock
// Notes:   Command strobes are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface dmsc_rtc_if;
  logic        tick;
  logic        load_time;
  logic        load_date;
  logic        round_min;
  logic        hour_fwd;
  logic        hour_back;
  logic [31:0] wdata;
  logic [5:0]  sec;
  logic [5:0]  min;
  logic [4:0]  hour;
  logic [4:0]  day;
  logic [3:0]  mon;
  logic [6:0]  year;
  logic [2:0]  wday;

  modport ctrl (output tick, load_time, load_date, round_min, hour_fwd,
                hour_back, wdata,
                input  sec, min, hour, day, mon, year, wday);
  modport core (input  tick, load_time, load_date, round_min, hour_fwd,
                hour_back, wdata,
                output sec, min, hour, day, mon, year, wday);
endinterface
`default_nettype wire

/* testbench/dmsc_pulse_src.sv */
// Purpose: Minute pulse source standing on the digital inputs
// Assumes: Pulses are launched right after a rising clock edge
// Notes:   Lines idle low; a pulse stays high six cycles
`timescale 1ns/100ps
`default_nettype none
module dmsc_pulse_src (
  // Clock
  input  wire logic        clk_i,
  // Digital input pins
  output var  logic [13:0] pin_o
);
  initial pin_o = 14'h0000;

  // pulse on input
  // One rising edge on the chosen pin, then a quiet gap
  task automatic pulse(input int idx);
    @(posedge clk_i);
    pin_o[idx] <= 1'b1;
    repeat (6) @(posedge clk_i);
    pin_o[idx] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for the local-time block
// Assumes: Registered one-wait-cycle Wishbone answer
// Notes:   Seconds ticks are driven by hand, one per call
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tick_i = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic        wb_ack_o, dst_active_o;
  logic [13:0] pins;
  logic [5:0]  sec_o, min_o;
  logic [4:0]  hour_o;
  logic [1:0]  date_order_o;
  logic [4:0]  day_o;
  logic [3:0]  mon_o, country_o;
  logic [6:0]  year_o;
  logic [2:0]  wday_o;
  logic [31:0] date_seen;
  int          fail_count = 0, n_tests = 0;

  // Clock generator
  always #2 clk_i = ~clk_i;

  dmsc_local_time u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tick_i(tick_i), .dig_in_i(pins), .sec_o(sec_o), .min_o(min_o),
    .hour_o(hour_o), .day_o(day_o), .mon_o(mon_o), .year_o(year_o),
    .wday_o(wday_o), .dst_active_o(dst_active_o),
    .date_order_o(date_order_o), .country_o(country_o));
  dmsc_pulse_src u_src (.clk_i(clk_i), .pin_o(pins));

  // Calendar outputs packed in the date register layout
  assign date_seen = {5'h0, wday_o, 1'b0, year_o, 4'h0, mon_o, 3'h0, day_o};

  // Verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic settime(input int h, input int m, input int s);
    xfer(1'b1, dmsc_pkg::ADR_TIME, 32'((h << 16) | (m << 8) | s));
    repeat (2) @(posedge clk_i);
  endtask

  task automatic chkt(input int h, input int m, input int s);
    chk({15'h0, hour_o, min_o, sec_o}, 32'((h << 12) | (m << 6) | s));
  endtask

  task automatic tick1;
    @(posedge clk_i);
    tick_i <= 1'b1;
    @(posedge clk_i);
    tick_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(dmsc_pkg::ADR_CTRL, 32'h0);
    rd(dmsc_pkg::ADR_START, 32'h2023);
    rd(dmsc_pkg::ADR_END, 32'h201b);
    rd(8'h18, 32'h0);
    chk({31'h0, dst_active_o}, 32'h0);
    chk({28'h0, country_o}, 32'h0);
    $display("test defaults done");
    for (int o = 0; o < 3; o++) begin
      xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'(o << 1));
      @(posedge clk_i);
      chk({30'h0, date_order_o}, 32'(o));
    end
    xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'h6);
    xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'h90);
    rd(dmsc_pkg::ADR_CTRL, 32'h4);
    xfer(1'b1, dmsc_pkg::ADR_START, 32'h0023);
    xfer(1'b1, dmsc_pkg::ADR_START, 32'h7023);
    rd(dmsc_pkg::ADR_START, 32'h2023);
    $display("test refusals done");
    xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'h0);
    xfer(1'b1, dmsc_pkg::ADR_DATE, 32'h0018_0308);
    @(posedge clk_i);
    chk(date_seen, 32'h0018_0308);
    settime(1, 59, 59);
    tick1();
    chkt(2, 0, 0);
    // Enable away from the start point so only the tick crosses it
    settime(1, 59, 59);
    xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'h1);
    tick1();
    chkt(3, 0, 0);
    rd(dmsc_pkg::ADR_STAT, 32'h1);
    $display("test dst start done");
    xfer(1'b1, dmsc_pkg::ADR_DATE, 32'h0018_0b1c);
    settime(1, 59, 59);
    tick1();
    chkt(2, 0, 0);
    // New end point set before the clock reaches it
    settime(1, 59, 59);
    xfer(1'b1, dmsc_pkg::ADR_END, 32'h205b);
    tick1();
    chkt(1, 0, 0);
    chk({31'h0, dst_active_o}, 32'h0);
    settime(1, 59, 59);
    tick1();
    chkt(2, 0, 0);
    $display("test dst end done");
    for (int s = 1; s <= 8; s++) begin
      xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'(s << 4));
      settime(10, 59, 45);
      u_src.pulse((s == 8) ? 13 : s - 1);
      chkt(11, 0, 0);
    end
    settime(10, 20, 10);
    u_src.pulse(0);
    chkt(10, 20, 10);
    u_src.pulse(13);
    chkt(10, 20, 0);
    xfer(1'b1, dmsc_pkg::ADR_CTRL, 32'h0);
    settime(10, 20, 40);
    u_src.pulse(13);
    chkt(10, 20, 40);
    $display("test minute sync done");
    end_of_test();
  end
endmodule
`default_nettype wire
